// ==== scs_pkg.sv ====
// Package of constants and types for the SAR conversion sequencer
package scs_pkg;
  // Converter geometry
  localparam int SCS_BITS = 16;
  localparam logic [15:0] SCS_CODE_MIN = 16'h0000;
  localparam logic [15:0] SCS_CODE_MAX = 16'hFFFF;
  localparam logic [15:0] SCS_CODE_MID = 16'h8000;
  localparam logic [15:0] SCS_TWOS_FLIP = 16'h8000;
  // Clock rate
  localparam int SCS_CLK_KHZ = 10000;
  // Timing: minimum period per mode in ns, warp gap limit in us
  localparam int SCS_WARP_PERIOD_NS = 1000;
  localparam int SCS_NORM_PERIOD_NS = 1250;
  localparam int SCS_WARP_GAP_US = 1000;
  localparam int SCS_WARP_GAP_CYC = (SCS_WARP_GAP_US * SCS_CLK_KHZ) / 1000;
  // Conversion steps: one bit trial each, one cycle for the code, acquisition cycles
  localparam int SCS_LP_ACQ_CYC = 4;
  // Register map of the plain register port
  localparam logic [3:0] SCS_REG_CTRL = 4'h0;
  localparam logic [3:0] SCS_REG_STATUS = 4'h1;
  localparam logic [3:0] SCS_REG_RESULT = 4'h2;
  localparam logic [3:0] SCS_REG_COUNT = 4'h3;
  // Control register fields
  localparam int SCS_CTRL_MODE_LSB = 0;
  localparam int SCS_CTRL_CODING_BIT = 2;
  localparam logic [2:0] SCS_CTRL_RESET = 3'h0;
  // Operating modes
  typedef enum logic [1:0] {
    SCS_MODE_WARP = 2'h0,
    SCS_MODE_NORMAL = 2'h1,
    SCS_MODE_LOWPOWER = 2'h2
  } scs_mode_e;
endpackage : scs_pkg

// ==== scs_sync.sv ====
// Three-stage synchroniser with agreement filter for a pin input
`timescale 1ns/100ps
module scs_sync #(
  parameter logic RESET_VAL = 1'b1
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Pin and filtered level
  input wire logic pin_in,
  output logic level_out
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  // Shift chain; only s2 reads s1
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s1_q <= RESET_VAL;
      s2_q <= RESET_VAL;
      s3_q <= RESET_VAL;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Level changes once second and third stage agree
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      level_out <= RESET_VAL;
    end else if (s2_q == s3_q) begin
      level_out <= s3_q;
    end
  end
endmodule : scs_sync

// ==== scs_fifo.sv ====
// Result FIFO with valid/ready on both sides
`timescale 1ns/100ps
module scs_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  // Fill level
  output logic [$clog2(DEPTH+1)-1:0] level
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [$clog2(DEPTH+1)-1:0] cnt_q;
  logic push;
  logic pop;

  // Handshake terms
  assign in_ready = (cnt_q != DEPTH[$clog2(DEPTH+1)-1:0]);
  assign out_valid = (cnt_q != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_q];
  assign level = cnt_q;

  // Storage array
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  // Pointers and count
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule : scs_fifo

// ==== scs_sequencer.sv ====
// SAR conversion sequencer: sampling, bit search, coding, result FIFO
//
// Overview of operation
// - Falling convert_start_n ends acquisition and starts a conversion.
// - Input minus ground-sense is frozen at conversion start and converted.
// - Successive approximation, MSB first, sixteen binary-weighted trials.
// - After the last bit the code is formed, then BUSY drops.
// - Each result belongs to its own sample, no pipeline latency.
// - Three modes: fastest, normal, low-power, chosen by the host.
// - Fastest mode runs to 1 MSPS; accuracy needs starts within 1 ms.
// - Normal mode runs to 800 kSPS with any start spacing.
// - Low-power mode cuts power between conversions.
// - Coding select picks straight binary or twos complement.
// - One step is reference/65536; twos complement inverts the MSB.
// - Over-range clamps to FFFF binary or 7FFF twos complement.
// - Under-range clamps to 0000 binary or 8000 twos complement.
// - Ground-sense is sampled at the same instant as the main input.
// - A started conversion always completes; no restart, no abort.
// - Low-power mode with start held low self-times acquisition and restarts.
`timescale 1ns/100ps
module scs_sequencer
  import scs_pkg::*;
#(
  parameter int BITS = scs_pkg::SCS_BITS,
  parameter int FIFO_DEPTH = 16,
  parameter int WARP_GAP_CYC = scs_pkg::SCS_WARP_GAP_CYC,
  parameter int LP_ACQ_CYC = scs_pkg::SCS_LP_ACQ_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Host pins
  input wire logic convert_start_n,
  input wire logic output_coding_select,
  input wire logic [1:0] mode_select,
  input wire logic power_down_input,
  // Analog front end, digitised sample values
  input wire logic [BITS-1:0] analog_in,
  input wire logic [BITS-1:0] input_ground_sense,
  input wire logic over_range,
  // Sample and hold control
  output logic hold,
  output logic analog_power_down,
  // Status pins
  output logic busy,
  output logic stale_result,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Result stream
  output logic res_valid,
  input wire logic res_ready,
  output logic [BITS-1:0] res_data
);
  import scs_pkg::*;

  // ==========================================================
  // Types and functions
  typedef enum {
    ST_ACQ,
    ST_CONV,
    ST_FORM,
    ST_PUSH
  } scs_state_e;

  // Apply output coding: twos complement inverts the MSB
  function automatic logic [BITS-1:0] scs_apply_coding(input logic [BITS-1:0] raw, input logic twos);
    scs_apply_coding = twos ? (raw ^ SCS_TWOS_FLIP[BITS-1:0]) : raw;
  endfunction : scs_apply_coding

  // Minimum cycles between starts for a mode period in ns, rounded up
  function automatic logic [15:0] scs_period_cyc(input int ns);
    scs_period_cyc = 16'((ns * (SCS_CLK_KHZ / 1000) + 999) / 1000);
  endfunction : scs_period_cyc

  // ==========================================================
  // Synchronised pins
  logic start_n_s;
  logic coding_s;
  logic pd_s;
  logic start_n_prev_q;
  logic start_fall;

  scs_sync #(.RESET_VAL(1'b1)) u_sync_start (
    .sys_clk(sys_clk),
    .rst(rst),
    .pin_in(convert_start_n),
    .level_out(start_n_s)
  );

  scs_sync #(.RESET_VAL(1'b0)) u_sync_pd (
    .sys_clk(sys_clk),
    .rst(rst),
    .pin_in(power_down_input),
    .level_out(pd_s)
  );

  scs_sync #(.RESET_VAL(1'b0)) u_sync_coding (
    .sys_clk(sys_clk),
    .rst(rst),
    .pin_in(output_coding_select),
    .level_out(coding_s)
  );

  // Edge detector on the filtered start level
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      start_n_prev_q <= 1'b1;
    end else begin
      start_n_prev_q <= start_n_s;
    end
  end

  assign start_fall = start_n_prev_q && !start_n_s;

  // ==========================================================
  // Control register: mode and coding override
  logic [2:0] ctrl_q;
  logic ctrl_en_q;
  scs_mode_e mode;
  logic twos;

  // Register writes
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= SCS_CTRL_RESET;
      ctrl_en_q <= 1'b0;
    end else if (reg_wr && reg_addr == SCS_REG_CTRL) begin
      ctrl_q <= reg_wdata[2:0];
      ctrl_en_q <= reg_wdata[15];
    end
  end

  // Mode from pins unless software takes over
  always_comb begin
    logic [1:0] m;
    m = ctrl_en_q ? ctrl_q[SCS_CTRL_MODE_LSB +: 2] : mode_select;
    case (m)
      2'h1: mode = SCS_MODE_NORMAL;
      2'h2: mode = SCS_MODE_LOWPOWER;
      default: mode = SCS_MODE_WARP;
    endcase
  end

  assign twos = ctrl_en_q ? ctrl_q[SCS_CTRL_CODING_BIT] : coding_s;

  // ==========================================================
  // Sequencer state
  scs_state_e state_q;
  logic [BITS-1:0] held_q;
  logic held_over_q;
  logic held_under_q;
  logic [BITS-1:0] trial_q;
  logic [BITS-1:0] bit_q;
  logic [BITS-1:0] code_q;
  logic [15:0] space_q;
  logic [7:0] acq_q;
  logic rate_ok;
  logic auto_start;
  logic go;
  logic fifo_in_ready;

  // Rate limiter: a new start is accepted once the mode's period has passed
  always_comb begin
    case (mode)
      SCS_MODE_WARP: rate_ok = (space_q >= scs_period_cyc(SCS_WARP_PERIOD_NS));
      SCS_MODE_NORMAL: rate_ok = (space_q >= scs_period_cyc(SCS_NORM_PERIOD_NS));
      default: rate_ok = (space_q >= scs_period_cyc(SCS_NORM_PERIOD_NS));
    endcase
  end

  // Low-power self-start when start is held low after acquisition time
  assign auto_start = (mode == SCS_MODE_LOWPOWER) && !start_n_s && (acq_q >= 8'(LP_ACQ_CYC));
  assign go = (state_q == ST_ACQ) && rate_ok && (start_fall || auto_start);

  // Acquisition timer for the self-start path
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      acq_q <= '0;
    end else if (state_q != ST_ACQ) begin
      acq_q <= '0;
    end else if (acq_q != 8'hFF) begin
      acq_q <= acq_q + 8'h01;
    end
  end

  // Start-to-start spacing counter, saturating
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      space_q <= 16'hFFFF;
    end else if (go) begin
      space_q <= 16'h0001;
    end else if (space_q != 16'hFFFF) begin
      space_q <= space_q + 16'h0001;
    end
  end

  // Main state machine; conversion ignores new starts and power-down
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_ACQ;
    end else begin
      case (state_q)
        ST_ACQ: if (go) state_q <= ST_CONV;
        ST_CONV: if (bit_q[0]) state_q <= ST_FORM;
        ST_FORM: state_q <= ST_PUSH;
        ST_PUSH: if (fifo_in_ready) state_q <= ST_ACQ;
        default: state_q <= ST_ACQ;
      endcase
    end
  end

  // Freeze input and ground-sense together at the start instant
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      held_q <= '0;
      held_over_q <= 1'b0;
      held_under_q <= 1'b0;
    end else if (go) begin
      held_under_q <= (analog_in < input_ground_sense);
      held_over_q <= over_range;
      held_q <= analog_in - input_ground_sense;
    end
  end

  // Bit search: trial bit walks MSB to LSB, compare against held value
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      trial_q <= '0;
      bit_q <= '0;
    end else if (go) begin
      trial_q <= '0;
      bit_q <= {1'b1, {(BITS-1){1'b0}}};
    end else if (state_q == ST_CONV) begin
      if ((trial_q | bit_q) <= held_q) begin
        trial_q <= trial_q | bit_q;
      end
      bit_q <= bit_q >> 1;
    end
  end

  // Output code with clamping and coding, from this sample only
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      code_q <= '0;
    end else if (state_q == ST_FORM) begin
      if (held_over_q) begin
        code_q <= scs_apply_coding(SCS_CODE_MAX[BITS-1:0], twos);
      end else if (held_under_q) begin
        code_q <= scs_apply_coding(SCS_CODE_MIN[BITS-1:0], twos);
      end else begin
        code_q <= scs_apply_coding(trial_q, twos);
      end
    end
  end

  // ==========================================================
  // Pin outputs
  logic busy_q;
  logic hold_q;
  logic apd_q;
  logic stale_q;
  logic [15:0] gap_q;
  logic [15:0] count_q;

  // BUSY high from start until the code is formed
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      busy_q <= 1'b0;
      hold_q <= 1'b0;
    end else begin
      busy_q <= go || (busy_q && state_q != ST_FORM);
      hold_q <= go || (hold_q && state_q == ST_CONV && !bit_q[0]);
    end
  end

  // Low-power mode powers the analog core down between conversions
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      apd_q <= 1'b0;
    end else begin
      apd_q <= (pd_s || mode == SCS_MODE_LOWPOWER) && state_q == ST_ACQ && !go;
    end
  end

  // Gap tracker: flags the first fast-mode result after a long idle
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      gap_q <= 16'hFFFF;
      stale_q <= 1'b1;
    end else if (go) begin
      stale_q <= (mode == SCS_MODE_WARP) && (gap_q > 16'(WARP_GAP_CYC));
      gap_q <= '0;
    end else if (gap_q != 16'hFFFF) begin
      gap_q <= gap_q + 16'h0001;
    end
  end

  // Completed conversion counter
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      count_q <= '0;
    end else if (state_q == ST_FORM) begin
      count_q <= count_q + 16'h0001;
    end
  end

  assign busy = busy_q;
  assign hold = hold_q;
  assign analog_power_down = apd_q;
  assign stale_result = stale_q;

  // ==========================================================
  // Result FIFO
  logic [$clog2(FIFO_DEPTH+1)-1:0] fifo_level;

  scs_fifo #(.WIDTH(BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sys_clk(sys_clk),
    .rst(rst),
    .in_valid(state_q == ST_PUSH),
    .in_ready(fifo_in_ready),
    .in_data(code_q),
    .out_valid(res_valid),
    .out_ready(res_ready),
    .out_data(res_data),
    .level(fifo_level)
  );

  // ==========================================================
  // Register read port, data one cycle after the strobe
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        SCS_REG_CTRL: reg_rdata <= {ctrl_en_q, 12'h000, ctrl_q};
        SCS_REG_STATUS: reg_rdata <= {8'h00, 3'(fifo_level >> 2), apd_q, stale_q, hold_q, mode == SCS_MODE_LOWPOWER, busy_q};
        SCS_REG_RESULT: reg_rdata <= 16'(code_q);
        SCS_REG_COUNT: reg_rdata <= count_q;
        default: reg_rdata <= 16'h0000;
      endcase
    end
  end
endmodule : scs_sequencer

// ==== scs_host.sv ====
// Host model: convert-start pulses and result stream acceptance
`timescale 1ns/100ps
module scs_host (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Bench commands
  input wire logic go,
  input wire logic hold_low,
  input wire logic ready_en,
  input wire logic slow,
  // Device side
  input wire logic stale_result,
  input wire logic res_valid,
  output logic convert_start_n,
  output logic res_ready
);
  logic [3:0] cnt_q;
  logic tog_q;
  logic discard_q;
  // Eight-cycle low pulse per command, or held low for self-timed runs
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) cnt_q <= 4'h0;
    else if (go) cnt_q <= 4'h8;
    else if (cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
  end
  assign convert_start_n = !(cnt_q != 4'h0 || hold_low);
  // Slow host accepts only on alternate cycles
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) tog_q <= 1'b0;
    else tog_q <= !tog_q;
  end
  assign res_ready = ready_en && !(slow && tog_q);
  // A result flagged stale after a long gap is only noted in discard_q; it is still accepted
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) discard_q <= 1'b0;
    else if (res_valid && res_ready) discard_q <= stale_result;
  end
endmodule : scs_host

// ==== scs_sequencer_chk.sv ====
// Concurrent checks on the sequencer ports
`timescale 1ns/100ps
module scs_chk #(
  parameter int BITS = 16
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Host pins
  input wire logic convert_start_n,
  input wire logic [1:0] mode_select,
  input wire logic power_down_input,
  // Status
  input wire logic hold,
  input wire logic analog_power_down,
  input wire logic busy,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  // Result stream
  input wire logic res_valid,
  input wire logic res_ready,
  input wire logic [BITS-1:0] res_data
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Sixteen trial cycles, then the formed code
  sequence s_trials;
    busy[*8] ##1 busy[*8];
  endsequence
  sequence s_idle4;
    (mode_select == 2'h2 && !busy && res_ready)[*4];
  endsequence
  a_trial_length: assert property ($rose(busy) |-> s_trials ##[1:15] !busy)
    else $error("conversion length wrong");
  a_hold_start: assert property ($rose(busy) |-> hold)
    else $error("sample not held at start");
  a_start_cause: assert property ($rose(busy) |-> !$past(convert_start_n, 2))
    else $error("conversion without start");
  a_awake_busy: assert property (busy && $past(busy) |-> !analog_power_down)
    else $error("powered down mid conversion");
  a_lp_sleep: assert property (s_idle4 |-> analog_power_down)
    else $error("low power idle not powered down");
  a_fast_awake: assert property ((mode_select == 2'h0 && !power_down_input)[*6] |-> !analog_power_down)
    else $error("fast mode powered down");
  a_unmapped_zero: assert property (reg_rd && reg_addr > 4'h3 |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_rdata_holds: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
    else $error("read data changed without read");
  a_result_stable: assert property (res_valid && !res_ready |=> res_valid && $stable(res_data))
    else $error("result dropped while stalled");
endmodule : scs_chk
bind scs_sequencer scs_chk #(.BITS(BITS)) u_chk (
  .sys_clk(sys_clk), .rst(rst), .convert_start_n(convert_start_n),
  .mode_select(mode_select), .power_down_input(power_down_input),
  .hold(hold), .analog_power_down(analog_power_down), .busy(busy),
  .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .res_valid(res_valid), .res_ready(res_ready), .res_data(res_data)
);

// ==== scs_sequencer_tb_top.sv ====
// Self-checking bench of the SAR conversion sequencer
`timescale 1ns/100ps
module scs_sequencer_tb_top;
  import scs_pkg::*;
  logic sys_clk, rst, go, hold_low, ready_en, slow, cod, pd, ovr, cstn;
  logic wr, rd, busy, hold, apd, stale, rvalid, rready, busy_d;
  logic [1:0] mode;
  logic [3:0] addr;
  logic [15:0] ain, agnd, wdata, rdata, rres, rd_v, last_code;
  logic [15:0] expq[$];
  logic [15:0] ca[5] = '{16'hFFFF, 16'h0000, 16'h8000, 16'h0005, 16'h1234};
  logic [15:0] cg[5] = '{16'h0000, 16'h0000, 16'h0000, 16'h0009, 16'h0034};
  logic co[5] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
  int err_total, num_checks, nconv, n0, i;
  scs_sequencer #(.WARP_GAP_CYC(50)) dut (
    .sys_clk(sys_clk), .rst(rst), .convert_start_n(cstn), .output_coding_select(cod),
    .mode_select(mode), .power_down_input(pd), .analog_in(ain), .input_ground_sense(agnd),
    .over_range(ovr), .hold(hold), .analog_power_down(apd), .busy(busy), .stale_result(stale),
    .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata),
    .res_valid(rvalid), .res_ready(rready), .res_data(rres)
  );
  scs_host host (
    .sys_clk(sys_clk), .rst(rst), .go(go), .hold_low(hold_low), .ready_en(ready_en),
    .slow(slow), .stale_result(stale), .res_valid(rvalid), .convert_start_n(cstn),
    .res_ready(rready)
  );
  // Clock of 100 ns
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = !sys_clk;
  end
  function automatic logic [15:0] model(int a, int g, bit o, bit c);
    int v;
    v = o ? 65535 : (a < g ? 0 : a - g);
    return 16'(v) ^ (c ? SCS_TWOS_FLIP : 16'h0000);
  endfunction : model
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %0t: %s seen %h exp %h", $time, msg, seen, exp);
    end
  endtask : chk
  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick
  task automatic wait_busy(input logic lvl);
    int k;
    for (k = 0; k < 60; k++) begin
      @(negedge sys_clk);
      if (busy === lvl) break;
    end
    if (busy !== lvl) begin
      chk(16'h0000, 16'h0001, "busy wait timeout");
      finish_test();
    end
    @(posedge sys_clk);
  endtask : wait_busy
  task automatic pulse_go();
    go <= 1'b1;
    @(posedge sys_clk);
    go <= 1'b0;
  endtask : pulse_go
  task automatic conv(input logic [1:0] m, input logic c, input logic [15:0] a, g, input logic o);
    mode <= m;
    cod <= c;
    ain <= a;
    agnd <= g;
    ovr <= o;
    tick(5);
    pulse_go();
    wait_busy(1'b1);
    wait_busy(1'b0);
    tick(3);
  endtask : conv
  task automatic reg_read(input logic [3:0] a, output logic [15:0] v);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    @(negedge sys_clk);
    v = rdata;
    @(posedge sys_clk);
  endtask : reg_read
  task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask : reg_write
  // Reference model: one code per conversion start, results checked in order
  always @(posedge sys_clk) begin
    busy_d <= busy;
    if (!rst && busy === 1'b1 && busy_d === 1'b0) begin
      last_code = model(ain, agnd, ovr, cod);
      expq.push_back(last_code);
      nconv++;
    end
    if (!rst && rvalid === 1'b1 && rready === 1'b1) begin
      if (expq.size() != 0) chk(rres, expq.pop_front(), "result");
      else chk(16'h0000, 16'h0001, "extra result");
    end
  end
  // Main sequence
  initial begin
    err_total = 0; num_checks = 0; nconv = 0; busy_d = 1'b0;
    rst = 1'b1; go = 1'b0; hold_low = 1'b0; ready_en = 1'b1; slow = 1'b0;
    cod = 1'b0; pd = 1'b0; ovr = 1'b0; mode = 2'h0; ain = 16'h0000; agnd = 16'h0000;
    addr = 4'h0; wdata = 16'h0000; wr = 1'b0; rd = 1'b0;
    void'($urandom(32'hACBF));
    tick(2);
    rst <= 1'b0;
    // Stale flag after a long idle gap, clear after a short one
    tick(60);
    conv(2'h0, 1'b0, 16'h0100, 16'h0000, 1'b0);
    chk(16'(stale), 16'h0001, "stale after gap");
    conv(2'h0, 1'b0, 16'h0200, 16'h0000, 1'b0);
    chk(16'(stale), 16'h0000, "stale short gap");
    // Every mode and coding with corner and random inputs
    for (i = 0; i < 14; i++) begin
      slow <= 1'($urandom);
      if (i < 5) conv(2'(i % 3), i[1], ca[i], cg[i], co[i]);
      else conv(2'(i % 3), i[0], 16'($urandom), 16'($urandom), 1'($urandom));
    end
    // Register port: last code, count, unmapped place, control readback
    reg_read(SCS_REG_RESULT, rd_v);
    chk(rd_v, last_code, "result reg");
    reg_read(SCS_REG_COUNT, rd_v);
    chk(rd_v, 16'(nconv), "count reg");
    reg_write(4'hB, 16'hFFFF);
    reg_read(4'hB, rd_v);
    chk(rd_v, 16'h0000, "unmapped read");
    reg_write(SCS_REG_CTRL, 16'h8005);
    reg_read(SCS_REG_CTRL, rd_v);
    chk(rd_v, 16'h8005, "ctrl readback");
    reg_write(SCS_REG_CTRL, 16'h0000);
    // New start and power-down during a conversion change nothing
    mode <= 2'h1; ain <= 16'h4321; agnd <= 16'h0021; ovr <= 1'b0; n0 = nconv;
    tick(5);
    pulse_go();
    wait_busy(1'b1);
    pd <= 1'b1;
    tick(6);
    pulse_go();
    wait_busy(1'b0);
    tick(8);
    chk(16'(apd), 16'h0001, "power down idle");
    chk(16'(nconv - n0), 16'h0001, "no restart");
    pd <= 1'b0;
    // Self-timed low-power runs fill the FIFO while the host stalls
    mode <= 2'h2; ready_en <= 1'b0; hold_low <= 1'b1; n0 = nconv;
    tick(800);
    hold_low <= 1'b0;
    tick(30);
    reg_read(SCS_REG_STATUS, rd_v);
    chk(16'(rd_v[7:5]), 16'h0004, "fifo full level");
    chk(16'(nconv - n0 >= 16 && nconv - n0 <= 17), 16'h0001, "self-timed runs");
    ready_en <= 1'b1;
    slow <= 1'b1;
    tick(120);
    reg_read(SCS_REG_STATUS, rd_v);
    chk(16'(rd_v[7:5]), 16'h0000, "fifo empty level");
    chk(16'(expq.size()), 16'h0000, "results missing");
    finish_test();
  end
endmodule : scs_sequencer_tb_top
